// ==== rtl/adc_ctrl_pkg.sv ====
/*
  Shared constants and types of the converter control block: register
  map of the byte-wide register port, field layouts, reset values, scan
  modes and carrier structs.
  Assumes the serial protocol front end presents decoded 7-bit register
  addresses and single-byte reads and writes.
*/
package adc_ctrl_pkg;

  // Register addresses on the byte-wide register port
  localparam logic [6:0] ADDR_SYSCAL  = 7'h00;  // Calibration control
  localparam logic [6:0] ADDR_SCAN    = 7'h01;  // Scan configuration
  localparam logic [6:0] ADDR_STATUS  = 7'h02;  // Pending and standby
  localparam logic [6:0] ADDR_AUX     = 7'h03;  // Excitation level
  localparam logic [6:0] ADDR_BURNOUT = 7'h04;  // Burnout enables, ch 0..6
  localparam logic [6:0] ADDR_THR_HI  = 7'h05;  // Short threshold high byte
  localparam logic [6:0] ADDR_THR_LO  = 7'h06;  // Short threshold low byte
  localparam logic [6:0] ADDR_DIAG    = 7'h07;  // Sensor diagnostic flags
  localparam logic [6:0] ADDR_RES_HI  = 7'h08;  // Result bits 23:16
  localparam logic [6:0] ADDR_RES_MID = 7'h09;  // Result bits 15:8
  localparam logic [6:0] ADDR_RES_LO  = 7'h0a;  // Result bits 7:0

  // Coefficient page: addr[6:5] selects it, addr[4:3] the set, addr[2:0] the byte
  localparam logic [1:0] COEF_PAGE    = 2'h1;
  localparam logic [2:0] B_OFF_HI     = 3'h0;
  localparam logic [2:0] B_OFF_MID    = 3'h1;
  localparam logic [2:0] B_OFF_LO     = 3'h2;
  localparam logic [2:0] B_GAIN_HI    = 3'h3;
  localparam logic [2:0] B_GAIN_MID   = 3'h4;
  localparam logic [2:0] B_GAIN_LO    = 3'h5;
  localparam logic [2:0] B_MULT       = 3'h6;
  localparam logic [2:0] B_SHIFT      = 3'h7;

  // Calibration control codes
  localparam logic [1:0] SYSCAL_NONE  = 2'h0;
  localparam logic [1:0] SYSCAL_OFF   = 2'h1;
  localparam logic [1:0] SYSCAL_GAIN  = 2'h3;

  // Diagnostic flag bit positions
  localparam int DIAG_SHORT = 7;
  localparam int DIAG_RAIL  = 6;
  localparam int DIAG_POR   = 5;

  // Reset values
  localparam logic [23:0] OFF_RST   = 24'h000000;
  localparam logic [23:0] GAIN_RST  = 24'h800000;  // Unity in 1.23
  localparam logic [7:0]  MULT_RST  = 8'h01;
  localparam logic [3:0]  SHIFT_RST = 4'h0;
  localparam logic [3:0]  EXC_RST   = 4'h0;
  localparam logic [3:0]  EXC_MAX   = 4'ha;        // 10 steps of 100 uA
  localparam logic [7:0]  THR_RST   = 8'h00;
  localparam logic [6:0]  BURN_RST  = 7'h00;

  // Divider: 48 quotient bits from a 1.23 gain
  localparam logic [5:0] DIV_LAST   = 6'h2f;
  localparam int         FRAC_BITS  = 23;

  // Scan modes
  typedef enum logic [1:0] {
    single_channel_continuous,
    multi_channel_once,
    multi_channel_repeat,
    multi_channel_repeat_diag_current
  } scan_mode_t;

  // Scan configuration byte
  typedef struct packed {
    scan_mode_t  mode;   // Bits 7:6
    logic [2:0]  last;   // Bits 5:3, scan_end_channel
    logic [2:0]  first;  // Bits 2:0, scan_start_channel
  } scan_cfg_t;

  localparam scan_cfg_t SCAN_RST = '{single_channel_continuous, 3'h0, 3'h0};

  // One finished conversion from the converter core
  typedef struct packed {
    logic [23:0] raw;        // Two's complement code
    logic [1:0]  ovr;        // overrange_code
    logic        near_rail;  // Channel within 50 mV of a rail
  } conv_res_t;

endpackage : adc_ctrl_pkg

// ==== rtl/adc_scan_syscal_diag_ctrl.sv ====
/*
  Control logic of a multi-channel sigma-delta front end: channel scan
  sequencer, system offset and gain calibration, post-calibration
  scaling, burnout current sequencing and sensor diagnostic flags.
  Assumes a converter core on the same clock that takes one start pulse
  per conversion and returns one done pulse with its result, and a
  serial front end that issues single-byte register reads and writes.

  // Behaviour
  // RQ1 - Code 1 stores fresh conversion as offset
  // RQ2 - Offset mode exits by itself
  // RQ3 - Code 3 overwrites gain with computed coefficient
  // RQ4 - Gain mode exits by itself
  // RQ5 - Software redoes offset, writes target gain first
  // RQ6 - Software averages results or picks slow rates
  // RQ7 - Result multiplied by scale, then shifted
  // RQ8 - Four coefficient sets, channels 4-6 share
  // RQ9 - Scan register double buffered with pending bit
  // RQ10 - Mode 0 converts first channel continuously
  // RQ11 - Mode 1 scans once then standby
  // RQ12 - Mode 2 scans first to last forever
  // RQ13 - Mode 3 injects burnout after conversion
  // RQ14 - Modes 0-2 inject into all enabled channels
  // RQ15 - Software avoids mode 0 at high gain
  // RQ16 - Excitation level 100 to 1000 uA steps
  // RQ17 - Short flag when magnitude within threshold
  // RQ18 - Rails flag when near a supply rail
  // RQ19 - Power-on flag cleared by diag read
  // RQ20 - Two-bit overrange code reported
  // RQ21 - Result channel is previous converted channel
  // RQ22 - Subtract offset, divide by 1.23 gain
  // RQ23 - Gain resets to 0x800000
  // RQ24 - Shift is right shift of product
*/
`timescale 1ns/10ps
module adc_scan_syscal_diag_ctrl (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  // Register port
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [6:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  // Converter core
  output logic                         conv_start_o,
  output logic      [2:0]              conv_chan_o,
  input  wire logic                    conv_done_i,
  input  wire adc_ctrl_pkg::conv_res_t conv_res_i,
  input  wire logic                    por_event_i,
  // Sensor drive
  output logic      [3:0]              excitation_level_o,
  output logic      [6:0]              burnout_o,
  // Result stream
  output logic      [23:0]             result_o,
  output logic                         result_valid_o,
  output logic                         standby_o
);

  typedef enum logic {seq_idle, seq_conv} seq_t;
  typedef enum logic [1:0] {cmp_idle, cmp_div, cmp_pub} cmp_t;
  typedef enum logic [1:0] {kind_norm, kind_off, kind_gain} kind_t;

  // Channels 4..6 fold onto sets 0..2, so the set is the low two bits
  function automatic logic [1:0] set_of(input logic [2:0] ch);
    return ch[1:0];  // [RQ8]
  endfunction : set_of

  function automatic logic [6:0] onehot(input logic [2:0] ch);
    return 7'(8'h01 << ch);
  endfunction : onehot

  // Coefficient sets
  logic [23:0] off_q   [4];              // chan_syscal_offset_coef
  logic [23:0] gain_q  [4];              // chan_syscal_gain_coef
  logic [7:0]  mult_q  [4];              // chan_post_scale_mult
  logic [3:0]  shift_q [4];              // chan_post_scale_shift

  // Software configuration
  logic [1:0]               syscal_q;    // syscal_control
  adc_ctrl_pkg::scan_cfg_t  slave_q;     // Written copy
  adc_ctrl_pkg::scan_cfg_t  act_q;       // Copy in use
  adc_ctrl_pkg::scan_cfg_t  cfg_now;
  logic                     pend_q;      // scan_update_pending
  logic [3:0]               exc_q;       // excitation_level_select
  logic [6:0]               burn_en_q;
  logic [7:0]               thr_hi_q;    // short_threshold_high
  logic [7:0]               thr_lo_q;    // short_threshold_low

  // Sequencer
  seq_t        seq_q;
  logic [2:0]  conv_ch_q;                // Channel now converting
  logic [2:0]  next_ch_q;
  logic        cal_conv_q;               // Running conversion is a calibration
  logic        cal_busy_q;
  logic        standby_q;
  logic        has_last_q;
  logic [2:0]  scan_end_channel_q;                // Channel that last finished
  logic        cal_go;
  logic        start;
  logic [2:0]  start_ch;
  logic        done;

  // Compute pipeline
  cmp_t                     cmp_q;
  kind_t                    kind_q;
  adc_ctrl_pkg::conv_res_t  cap_q;
  logic [2:0]               cap_ch_q;
  logic                     neg_q;
  logic [47:0]              num_q;       // Numerator, becomes quotient
  logic [23:0]              den_q;
  logic [23:0]              rem_q;
  logic [5:0]               cnt_q;
  logic [24:0]              trial;
  logic                     ge;
  logic [24:0]              diff;
  logic [24:0]              mag;
  logic [23:0]              qmag;
  logic signed [23:0]       qsig;
  logic signed [32:0]       prod;
  logic signed [32:0]       shifted;
  logic [23:0]              raw_abs;
  logic                     cal_store;

  // Diagnostic flags
  logic        short_q;
  logic        rail_q;
  logic        por_q;                    // power_on_since_read_flag
  logic [1:0]  ovr_q;                    // overrange_code
  logic [2:0]  rch_q;                    // result_channel_id
  logic [7:0]  diag;

  // Register decode
  logic        wr_coef;
  logic [1:0]  wset;
  logic [2:0]  wbyte;

  assign wr_coef = reg_wr_i && (reg_addr_i[6:5] == adc_ctrl_pkg::COEF_PAGE);
  assign wset    = reg_addr_i[4:3];
  assign wbyte   = reg_addr_i[2:0];
  assign cfg_now = pend_q ? slave_q : act_q;

  // Calibration control; writes are ignored while busy, so the clear cycle wins over a new code
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      syscal_q <= adc_ctrl_pkg::SYSCAL_NONE;
    end else if (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_SYSCAL && !cal_busy_q &&
                 (reg_wdata_i[1:0] == adc_ctrl_pkg::SYSCAL_OFF ||
                  reg_wdata_i[1:0] == adc_ctrl_pkg::SYSCAL_GAIN)) begin
      syscal_q <= reg_wdata_i[1:0];  // [RQ1] [RQ3]
    end else if (cal_store) begin
      syscal_q <= adc_ctrl_pkg::SYSCAL_NONE;  // [RQ2] [RQ4]
    end
  end

  // Scan register: writes land in the slave copy, locked while pending
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slave_q <= adc_ctrl_pkg::SCAN_RST;
      act_q   <= adc_ctrl_pkg::SCAN_RST;
      pend_q  <= 1'b0;
    end else if (start && pend_q) begin
      act_q  <= slave_q;  // [RQ9]
      pend_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_SCAN && !pend_q) begin
      slave_q <= adc_ctrl_pkg::scan_cfg_t'(reg_wdata_i);  // [RQ9] [RQ10]
      pend_q  <= 1'b1;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exc_q     <= adc_ctrl_pkg::EXC_RST;
      burn_en_q <= adc_ctrl_pkg::BURN_RST;
      thr_hi_q  <= adc_ctrl_pkg::THR_RST;
      thr_lo_q  <= adc_ctrl_pkg::THR_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        // Out-of-range codes clamp to the 1000 uA step
        adc_ctrl_pkg::ADDR_AUX:     exc_q <= (reg_wdata_i[3:0] > adc_ctrl_pkg::EXC_MAX) ?
                                             adc_ctrl_pkg::EXC_MAX : reg_wdata_i[3:0];  // [RQ16]
        adc_ctrl_pkg::ADDR_BURNOUT: burn_en_q <= reg_wdata_i[6:0];
        adc_ctrl_pkg::ADDR_THR_HI:  thr_hi_q  <= reg_wdata_i;
        adc_ctrl_pkg::ADDR_THR_LO:  thr_lo_q  <= reg_wdata_i;
        default:                    ;
      endcase
    end
  end

  // Coefficient sets; a calibration store wins over a same-cycle write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        off_q[i]   <= adc_ctrl_pkg::OFF_RST;
        gain_q[i]  <= adc_ctrl_pkg::GAIN_RST;  // [RQ23]
        mult_q[i]  <= adc_ctrl_pkg::MULT_RST;
        shift_q[i] <= adc_ctrl_pkg::SHIFT_RST;
      end
    end else if (cal_store) begin
      if (kind_q == kind_off) begin
        off_q[set_of(cap_ch_q)] <= cap_q.raw;  // [RQ1]
      end else begin
        // Quotient beyond 24 bits saturates
        gain_q[set_of(cap_ch_q)] <= (|num_q[47:24]) ? 24'hffffff : num_q[23:0];  // [RQ3]
      end
    end else if (wr_coef) begin
      case (wbyte)
        adc_ctrl_pkg::B_OFF_HI:   off_q[wset][23:16]  <= reg_wdata_i;
        adc_ctrl_pkg::B_OFF_MID:  off_q[wset][15:8]   <= reg_wdata_i;
        adc_ctrl_pkg::B_OFF_LO:   off_q[wset][7:0]    <= reg_wdata_i;
        adc_ctrl_pkg::B_GAIN_HI:  gain_q[wset][23:16] <= reg_wdata_i;
        adc_ctrl_pkg::B_GAIN_MID: gain_q[wset][15:8]  <= reg_wdata_i;
        adc_ctrl_pkg::B_GAIN_LO:  gain_q[wset][7:0]   <= reg_wdata_i;
        adc_ctrl_pkg::B_MULT:     mult_q[wset]        <= reg_wdata_i;
        default:                  shift_q[wset]       <= reg_wdata_i[3:0];
      endcase
    end
  end

  // Start decision: pending scan update, calibration, or free running
  assign cal_go   = (syscal_q != adc_ctrl_pkg::SYSCAL_NONE) && !cal_busy_q;
  assign start    = (seq_q == seq_idle) && (!standby_q || pend_q || cal_go);
  assign start_ch = (pend_q || cal_go) ? cfg_now.first : next_ch_q;
  assign done     = (seq_q == seq_conv) && conv_done_i;

  // Sequencer: one conversion in flight, next channel chosen on done
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_q      <= seq_idle;
      conv_ch_q  <= 3'h0;
      next_ch_q  <= 3'h0;
      cal_conv_q <= 1'b0;
      cal_busy_q <= 1'b0;
      standby_q  <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= start;
      if (cal_store) begin
        cal_busy_q <= 1'b0;
      end
      case (seq_q)
        seq_idle: begin
          if (start) begin
            seq_q      <= seq_conv;
            conv_ch_q  <= start_ch;
            cal_conv_q <= cal_go;  // [RQ1] [RQ3]
            standby_q  <= 1'b0;
            if (cal_go) begin
              cal_busy_q <= 1'b1;
            end
          end
        end
        seq_conv: begin
          if (conv_done_i) begin
            seq_q <= seq_idle;
            if (cal_conv_q) begin
              next_ch_q <= act_q.first;
            end else begin
              case (act_q.mode)
                adc_ctrl_pkg::single_channel_continuous: begin
                  next_ch_q <= act_q.first;  // [RQ10]
                end
                adc_ctrl_pkg::multi_channel_once: begin
                  if (conv_ch_q == act_q.last) begin
                    next_ch_q <= act_q.first;
                    standby_q <= 1'b1;  // [RQ11]
                  end else begin
                    next_ch_q <= conv_ch_q + 3'h1;
                  end
                end
                default: begin
                  // Modes 2 and 3 wrap to the first channel
                  next_ch_q <= (conv_ch_q == act_q.last) ?
                               act_q.first : conv_ch_q + 3'h1;  // [RQ12] [RQ13]
                end
              endcase
            end
          end
        end
        default: seq_q <= seq_idle;
      endcase
    end
  end

  assign conv_chan_o = conv_ch_q;
  assign standby_o   = standby_q;

  // Burnout currents; mode 3 follows the channel that just finished
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      has_last_q <= 1'b0;
      scan_end_channel_q  <= 3'h0;
      burnout_o  <= 7'h00;
    end else begin
      if (done) begin
        has_last_q <= 1'b1;
        scan_end_channel_q  <= conv_ch_q;
      end
      if (act_q.mode == adc_ctrl_pkg::multi_channel_repeat_diag_current) begin
        // Masked off a channel while it is itself converting
        burnout_o <= (has_last_q ? burn_en_q & onehot(scan_end_channel_q) : 7'h00) &
                     ~((seq_q == seq_conv) ? onehot(conv_ch_q) : 7'h00);  // [RQ13]
      end else begin
        burnout_o <= burn_en_q;  // [RQ14]
      end
    end
  end

  // Offset subtraction and magnitude feeding the divider
  assign diff  = {cap_q.raw[23], cap_q.raw} - {off_q[set_of(cap_ch_q)][23],
                                               off_q[set_of(cap_ch_q)]};  // [RQ22]
  assign mag   = diff[24] ? 25'(-diff) : diff;
  assign trial = {rem_q, num_q[47]};
  assign ge    = trial >= {1'b0, den_q};

  // Compute: restoring divide, then scale and publish
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_q    <= cmp_idle;
      kind_q   <= kind_norm;
      cap_q    <= '0;
      cap_ch_q <= 3'h0;
      neg_q    <= 1'b0;
      num_q    <= 48'h0;
      den_q    <= 24'h0;
      rem_q    <= 24'h0;
      cnt_q    <= 6'h0;
    end else begin
      case (cmp_q)
        cmp_idle: begin
          // A conversion done while busy is dropped; conversions are slow
          if (done) begin
            cap_q    <= conv_res_i;
            cap_ch_q <= conv_ch_q;
            if (!cal_conv_q) begin
              kind_q <= kind_norm;
              cmp_q  <= cmp_div;
            end else if (syscal_q == adc_ctrl_pkg::SYSCAL_OFF) begin
              kind_q <= kind_off;
              cmp_q  <= cmp_pub;
            end else begin
              kind_q <= kind_gain;
              cmp_q  <= cmp_div;
            end
          end
        end
        cmp_div: begin
          if (cnt_q == 6'h0 && num_q == 48'h0 && rem_q == 24'h0 && den_q == 24'h0) begin
            // Load operands one cycle after capture
            neg_q <= diff[24];
            num_q <= 48'({mag, 23'h0});  // [RQ22]
            den_q <= gain_q[set_of(cap_ch_q)];
            rem_q <= 24'h0;
            cnt_q <= 6'h1;
          end else begin
            rem_q <= ge ? 24'(trial - {1'b0, den_q}) : trial[23:0];
            num_q <= {num_q[46:0], ge};
            if (cnt_q == adc_ctrl_pkg::DIV_LAST + 6'h1) begin
              cmp_q <= cmp_pub;
            end
            cnt_q <= cnt_q + 6'h1;
          end
        end
        cmp_pub: begin
          cmp_q <= cmp_idle;
          num_q <= 48'h0;
          den_q <= 24'h0;
          rem_q <= 24'h0;
          cnt_q <= 6'h0;
        end
        default: cmp_q <= cmp_idle;
      endcase
    end
  end

  assign cal_store = (cmp_q == cmp_pub) && (kind_q != kind_norm);

  // Calibrated value saturated to signed 24 bits, then scaled
  assign qmag    = (|num_q[47:23]) ? 24'h7fffff : num_q[23:0];
  assign qsig    = neg_q ? -$signed(qmag) : $signed(qmag);
  // Widen before multiplying so the product keeps its top bits
  assign prod    = 33'(qsig) * 33'($signed({1'b0, mult_q[set_of(cap_ch_q)]}));  // [RQ7]
  assign shifted = prod >>> shift_q[set_of(cap_ch_q)];  // [RQ7] [RQ24]
  assign raw_abs = cap_q.raw[23] ? 24'(-cap_q.raw) : cap_q.raw;

  // Result and flags change together, so they name the finished channel
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_o       <= 24'h0;
      result_valid_o <= 1'b0;
      short_q        <= 1'b0;
      rail_q         <= 1'b0;
      ovr_q          <= 2'h0;
      rch_q          <= 3'h0;
    end else begin
      result_valid_o <= 1'b0;
      if (cmp_q == cmp_pub && kind_q == kind_norm) begin
        result_o       <= shifted[23:0];
        result_valid_o <= 1'b1;
        short_q        <= raw_abs <= {thr_hi_q, thr_lo_q};  // [RQ17]
        rail_q         <= cap_q.near_rail;  // [RQ18]
        ovr_q          <= cap_q.ovr;  // [RQ20]
        rch_q          <= cap_ch_q;  // [RQ21]
      end
    end
  end

  // Power-on flag: starts set, read clears, a new event wins the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_q <= 1'b1;
    end else if (por_event_i) begin
      por_q <= 1'b1;  // [RQ19]
    end else if (reg_rd_i && reg_addr_i == adc_ctrl_pkg::ADDR_DIAG) begin
      por_q <= 1'b0;  // [RQ19]
    end
  end

  always_comb begin
    diag                           = {3'h0, ovr_q, rch_q};
    diag[adc_ctrl_pkg::DIAG_SHORT] = short_q;
    diag[adc_ctrl_pkg::DIAG_RAIL]  = rail_q;
    diag[adc_ctrl_pkg::DIAG_POR]   = por_q;
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i[6:5] == adc_ctrl_pkg::COEF_PAGE) begin
        case (wbyte)
          adc_ctrl_pkg::B_OFF_HI:   reg_rdata_o <= off_q[wset][23:16];
          adc_ctrl_pkg::B_OFF_MID:  reg_rdata_o <= off_q[wset][15:8];
          adc_ctrl_pkg::B_OFF_LO:   reg_rdata_o <= off_q[wset][7:0];
          adc_ctrl_pkg::B_GAIN_HI:  reg_rdata_o <= gain_q[wset][23:16];
          adc_ctrl_pkg::B_GAIN_MID: reg_rdata_o <= gain_q[wset][15:8];
          adc_ctrl_pkg::B_GAIN_LO:  reg_rdata_o <= gain_q[wset][7:0];
          adc_ctrl_pkg::B_MULT:     reg_rdata_o <= mult_q[wset];
          default:                  reg_rdata_o <= {4'h0, shift_q[wset]};
        endcase
      end else begin
        case (reg_addr_i)
          adc_ctrl_pkg::ADDR_SYSCAL:  reg_rdata_o <= {6'h0, syscal_q};
          adc_ctrl_pkg::ADDR_SCAN:    reg_rdata_o <= cfg_now;
          adc_ctrl_pkg::ADDR_STATUS:  reg_rdata_o <= {6'h0, standby_q, pend_q};  // [RQ9]
          adc_ctrl_pkg::ADDR_AUX:     reg_rdata_o <= {4'h0, exc_q};
          adc_ctrl_pkg::ADDR_BURNOUT: reg_rdata_o <= {1'b0, burn_en_q};
          adc_ctrl_pkg::ADDR_THR_HI:  reg_rdata_o <= thr_hi_q;
          adc_ctrl_pkg::ADDR_THR_LO:  reg_rdata_o <= thr_lo_q;
          adc_ctrl_pkg::ADDR_DIAG:    reg_rdata_o <= diag;
          adc_ctrl_pkg::ADDR_RES_HI:  reg_rdata_o <= result_o[23:16];
          adc_ctrl_pkg::ADDR_RES_MID: reg_rdata_o <= result_o[15:8];
          adc_ctrl_pkg::ADDR_RES_LO:  reg_rdata_o <= result_o[7:0];
          default:                    reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  assign excitation_level_o = exc_q;

endmodule : adc_scan_syscal_diag_ctrl

// ==== sim/adc_conv_model.sv ====
/* Converter core stand-in: one done pulse DLY cycles after each start.
   Assumes the block's clock and reset. */
`timescale 1ns/10ps
module adc_conv_model #(parameter int DLY = 60) (
  // Control from the block
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  // Result back
  output logic            done_o,
  output adc_ctrl_pkg::conv_res_t res_o
);
  int          cnt = 0;     // Cycles left in the conversion
  logic        d_q = 1'b0;  // Done pulse
  logic [2:0]  ch_q = 3'h0; // Channel being converted
  logic [26:0] r;           // Raw 0x100+ch, overrange=ch[1:0], rail=ch[0]
  // Count down; a done only ever follows a start
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 0;
      d_q <= 1'b0;
    end else begin
      d_q <= (cnt == 1);
      if (start_i) begin
        cnt  <= DLY;
        ch_q <= chan_i;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  assign r = {24'h000100 + {21'h0, ch_q}, ch_q[1:0], ch_q[0]};
  // Result lines are meaningless outside done, so show garbage there
  assign res_o  = d_q ? r : ~r;
  assign done_o = d_q;
endmodule : adc_conv_model

// ==== sim/adc_scan_syscal_diag_ctrl_chk.sv ====
/* Port checker for the control block.
   Assumes it is bound onto the block. */
`timescale 1ns/10ps
module adc_ctrl_chk (
  input wire logic clk_i, arst_n_i, reg_wr_i, reg_rd_i, conv_done_i, por_event_i,
  input wire logic [6:0] reg_addr_i, burnout_o,
  input wire logic [7:0] reg_wdata_i, reg_rdata_o,
  input wire logic conv_start_o, result_valid_o, standby_o,
  input wire logic [2:0] conv_chan_o,
  input wire adc_ctrl_pkg::conv_res_t conv_res_i,
  input wire logic [3:0] excitation_level_o,
  input wire logic [23:0] result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_start; conv_start_o |=> !conv_start_o; endproperty
  a_start: assert property (p_start) else $error("start wider than one cycle");
  property p_chan; $changed(conv_chan_o) |-> conv_start_o; endproperty
  a_chan: assert property (p_chan) else $error("channel moved without start");
  property p_valid; result_valid_o |=> !result_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("valid wider than one cycle");
  property p_lat; result_valid_o |-> $past(conv_done_i, 51); endproperty
  a_lat: assert property (p_lat) else $error("result not 51 after done");
  property p_exc; excitation_level_o <= 4'ha; endproperty
  a_exc: assert property (p_exc) else $error("excitation above 1000 uA");
  // Standby means no new conversions
  property p_stby; standby_o [*3] |-> !conv_start_o; endproperty
  a_stby: assert property (p_stby) else $error("start in standby");
  property p_rd; !$past(reg_rd_i) |-> $stable(reg_rdata_o); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  // Burnout only moves on a write or around a conversion boundary
  property p_burn;
    $changed(burnout_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2) || conv_start_o
      || $past(conv_start_o) || $past(conv_done_i) || $past(conv_done_i, 2);
  endproperty
  a_burn: assert property (p_burn) else $error("burnout moved unprompted");
  c_valid: cover property (result_valid_o);
  c_stby: cover property ($rose(standby_o));
  c_burn: cover property (burnout_o != 7'h00);
endmodule : adc_ctrl_chk
bind adc_scan_syscal_diag_ctrl adc_ctrl_chk u_chk (.*);

// ==== sim/adc_scan_syscal_diag_ctrl_tb_top.sv ====
/* Register-level testbench of the control block.
   Assumes the converter stand-in and the bound checker. */
`timescale 1ns/10ps
module adc_scan_syscal_diag_ctrl_tb_top;
  logic clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rec = 1'b0;
  logic por_event_i = 1'b0; // Pulsed once mid-run
  logic [6:0] reg_addr_i = 7'h00, burnout_o;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic conv_start_o, conv_done_i, result_valid_o, standby_o;
  logic [2:0] conv_chan_o, q[$];
  logic [3:0] excitation_level_o;
  logic [23:0] result_o;
  adc_ctrl_pkg::conv_res_t conv_res_i;
  int num_errors = 0, tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  adc_scan_syscal_diag_ctrl uut (.*);
  adc_conv_model cm (.clk_i, .arst_n_i, .start_i(conv_start_o), .chan_i(conv_chan_o),
    .done_o(conv_done_i), .res_o(conv_res_i));
  // Log started channels while recording
  always @(posedge clk_i) if (rec && conv_start_o) q.push_back(conv_chan_o);
  task chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data lands on the edge that takes the strobe
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk({16'h0, reg_rdata_o}, {16'h0, e});
  endtask : rd
  task wv;
    @(posedge clk_i); #1;
    while (result_valid_o !== 1'b1) begin @(posedge clk_i); #1; end
  endtask : wv
  task end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(7'h23, 8'h80);
    rd(7'h26, 8'h01);
    rd(7'h07, 8'h20);
    rd(7'h07, 8'h00);
    // Noise-free stand-in, one determination suffices; unity gain only
    wr(7'h00, 8'h01);
    wv;
    chk(result_o, 24'h000100);
    wv;
    chk(result_o, 24'h000000);
    rd(7'h21, 8'h01);
    rd(7'h00, 8'h00);
    wr(7'h01, 8'h51);
    rec <= 1'b1;
    rd(7'h02, 8'h01);
    wr(7'h01, 8'h00);
    wait (standby_o === 1'b1);
    rd(7'h01, 8'h51);
    rd(7'h02, 8'h02);
    chk(24'(q.size()), 24'h000002);
    chk(24'({q[0], q[1]}), 24'h00000a);
    wv;
    rd(7'h07, 8'h12);
    wr(7'h05, 8'h01);
    wr(7'h06, 8'h02);
    wr(7'h36, 8'h04);
    wr(7'h37, 8'h01);
    wr(7'h01, 8'h52);
    wv;
    chk(result_o, 24'h000204);
    @(posedge clk_i) por_event_i <= 1'b1;
    @(posedge clk_i) por_event_i <= 1'b0;
    rd(7'h07, 8'hb2);
    rd(7'h07, 8'h92);
    wr(7'h33, 8'h00);
    wr(7'h34, 8'h02);
    wr(7'h35, 8'h04);
    wr(7'h00, 8'h03);
    wv;
    chk(result_o, 24'h000408);
    rd(7'h33, 8'h40);
    rd(7'h00, 8'h00);
    wr(7'h03, 8'h0f);
    rd(7'h03, 8'h0a);
    wr(7'h04, 8'h04);
    repeat (2) @(posedge clk_i);
    #1 chk({20'h0, excitation_level_o}, 24'h00000a);
    chk({17'h0, burnout_o}, 24'h000004);
    wr(7'h01, 8'hd1);
    repeat (10) @(posedge clk_i);
    #1 chk({17'h0, burnout_o}, 24'h000004);
    repeat (80) @(posedge clk_i);
    #1 chk({17'h0, burnout_o}, 24'h000000);
    end_sim();
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
endmodule : adc_scan_syscal_diag_ctrl_tb_top
